// [design/rtc_irq_pkg.sv]
package rtc_irq_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 8'h01;
    localparam logic [ADDR_W-1:0] IRQ_FLAGS_ADDR = 8'h02;

    // ************************************************************
    // field layout shared by the enable and flag registers
    // ************************************************************
    localparam int SRC_N = 5;
    localparam int ALARM_BIT = 0;
    localparam int TIMER_BIT = 1;
    localparam int LOW_VOLT1_BIT = 2;
    localparam int LOW_VOLT2_BIT = 3;
    localparam int RECOVERY_BIT = 4;

    // ************************************************************
    // alarm field layout
    // ************************************************************
    localparam int ALARM_FIELDS = 7;
    localparam int ALARM_FIELD_ENABLE_BIT = 7;
    localparam int ALARM_VALUE_W = 7;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [SRC_N-1:0] IRQ_ENABLE_RESET = 5'h00;
    localparam logic [SRC_N-1:0] IRQ_FLAGS_RESET = 5'h00;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

endpackage

// [design/rtc_irq_and_alarm_match.sv]
`timescale 1ns/1ps

// Functional notes
// - Bits 7 to 5 of enable and flag registers read as zero.
// - Timer flag sets on countdown end only while timer enable is one.
// - Each alarm field has its own enable at bit 7; disabled fields are ignored.
// - Enabled alarm fields are compared with the matching current watch value.
// - Alarm flag sets when enabled and all enabled comparisons first match together.
// - Alarm flag and request persist until software writes zero to it.
// - After clearing, alarm flag sets again only on a fresh match.
// - Request pin is active low open-drain: pulls low or releases.
// - Request follows flag bits 0 to 4 at 02h gated by their enables.
// - Writing zero to alarm or timer flag releases request if nothing else pending.
// - Low-voltage 1 request releases only when its flag and status are both clear.
// - Low-voltage 2 request releases only when its flag and status are both clear.
// - Recovery request releases only when its flag and status are both clear.
// - Timer flag and request stay set until software writes zero to it.
// - Recovery flag sets when a self-recovery reset has been executed.
module rtc_irq_and_alarm_match #(
    parameter int FIELDS = rtc_irq_pkg::ALARM_FIELDS
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [rtc_irq_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [rtc_irq_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [rtc_irq_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic [FIELDS*rtc_irq_pkg::DATA_W-1:0] alarm_fields_i,
    input wire logic [FIELDS*rtc_irq_pkg::DATA_W-1:0] watch_values_i,
    input wire logic timer_zero_i,
    input wire logic low_volt1_event_i,
    input wire logic low_volt2_event_i,
    input wire logic recovery_event_i,
    input wire logic low_volt1_status_i,
    input wire logic low_volt2_status_i,
    input wire logic recovery_status_i,
    output logic irq_n_o,
    output logic irq_n_oe_o
);

    localparam int DW = rtc_irq_pkg::DATA_W;
    localparam int SN = rtc_irq_pkg::SRC_N;

    initial begin
        if (FIELDS < 1 || FIELDS > rtc_irq_pkg::ALARM_FIELDS) begin
            $error("FIELDS out of range");
        end
    end

    // ************************************************************
    // register decode
    // ************************************************************
    wire logic enable_sel = (reg_addr_i == rtc_irq_pkg::IRQ_ENABLE_ADDR);
    wire logic flags_sel = (reg_addr_i == rtc_irq_pkg::IRQ_FLAGS_ADDR);
    wire logic enable_wr = reg_wr_i && enable_sel;
    wire logic flags_wr = reg_wr_i && flags_sel;

    logic [SN-1:0] enable_q;
    logic [SN-1:0] enable_d;
    logic [SN-1:0] flags_q;
    logic [SN-1:0] flags_d;
    logic match_prev_q;
    logic [DW-1:0] rdata_d;
    logic [DW-1:0] rdata_q;
    logic irq_oe_q;
    logic irq_oe_d;

    // ************************************************************
    // alarm comparison
    // ************************************************************
    logic [FIELDS-1:0] field_ok;
    logic [FIELDS-1:0] field_on;

    genvar g;
    generate
        for (g = 0; g < FIELDS; g++) begin : g_field
            wire logic [DW-1:0] alarm_byte = alarm_fields_i[g*DW +: DW];
            wire logic [DW-1:0] watch_byte = watch_values_i[g*DW +: DW];
            assign field_on[g] = alarm_byte[rtc_irq_pkg::ALARM_FIELD_ENABLE_BIT];
            // a disabled field counts as matching so it drops out of the AND
            assign field_ok[g] = !field_on[g] ||
                (alarm_byte[rtc_irq_pkg::ALARM_VALUE_W-1:0] ==
                 watch_byte[rtc_irq_pkg::ALARM_VALUE_W-1:0]);
        end
    endgenerate

    // with no field enabled there is nothing to match, so no alarm fires
    wire logic alarm_match = (|field_on) && (&field_ok);
    // only the first cycle of a match counts; a lasting match cannot retrigger
    wire logic alarm_rise = alarm_match && !match_prev_q;

    // ************************************************************
    // flag set and clear
    // ************************************************************
    logic [SN-1:0] flag_set;
    always_comb begin
        flag_set = '0;
        flag_set[rtc_irq_pkg::ALARM_BIT] = alarm_rise && enable_q[rtc_irq_pkg::ALARM_BIT];
        flag_set[rtc_irq_pkg::TIMER_BIT] = timer_zero_i && enable_q[rtc_irq_pkg::TIMER_BIT];
        flag_set[rtc_irq_pkg::LOW_VOLT1_BIT] = low_volt1_event_i;
        flag_set[rtc_irq_pkg::LOW_VOLT2_BIT] = low_volt2_event_i;
        flag_set[rtc_irq_pkg::RECOVERY_BIT] = recovery_event_i;
    end

    // write-zero clears, write-one keeps, and a new event wins over a clear
    wire logic [SN-1:0] flag_keep = flags_wr ? (flags_q & reg_wdata_i[SN-1:0]) : flags_q;
    assign flags_d = flag_keep | flag_set;
    assign enable_d = enable_wr ? reg_wdata_i[SN-1:0] : enable_q;

    // ************************************************************
    // request pin
    // ************************************************************
    logic [SN-1:0] held;
    always_comb begin
        held = flags_d;
        // status bits live elsewhere; they keep the request up until cleared too
        held[rtc_irq_pkg::LOW_VOLT1_BIT] = flags_d[rtc_irq_pkg::LOW_VOLT1_BIT] || low_volt1_status_i;
        held[rtc_irq_pkg::LOW_VOLT2_BIT] = flags_d[rtc_irq_pkg::LOW_VOLT2_BIT] || low_volt2_status_i;
        held[rtc_irq_pkg::RECOVERY_BIT] = flags_d[rtc_irq_pkg::RECOVERY_BIT] || recovery_status_i;
    end
    // computed from the next state so a clearing write releases on the same edge
    assign irq_oe_d = |(enable_d & held);

    // ************************************************************
    // read path
    // ************************************************************
    wire logic [DW-1:0] enable_word = {{(DW-SN){1'b0}}, enable_q};
    wire logic [DW-1:0] flags_word = {{(DW-SN){1'b0}}, flags_q};
    assign rdata_d = !reg_rd_i ? rdata_q :
                     enable_sel ? enable_word :
                     flags_sel ? flags_word : rtc_irq_pkg::READ_IDLE;

    // ************************************************************
    // state
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            enable_q <= rtc_irq_pkg::IRQ_ENABLE_RESET;
            flags_q <= rtc_irq_pkg::IRQ_FLAGS_RESET;
            match_prev_q <= 1'b0;
            rdata_q <= rtc_irq_pkg::READ_IDLE;
            irq_oe_q <= 1'b0;
        end else begin
            enable_q <= enable_d;
            flags_q <= flags_d;
            match_prev_q <= alarm_match;
            rdata_q <= rdata_d;
            irq_oe_q <= irq_oe_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    // open drain: the pin is only ever driven low, never high
    assign irq_n_o = 1'b0;
    assign irq_n_oe_o = irq_oe_q;

endmodule

// [sim/irq_host_model.sv]
`timescale 1ns/1ps
// ****
// host side of the request line
// ****
module irq_host_model (
    input wire logic irq_n_o,
    input wire logic irq_n_oe_o,
    output logic line_o
);
    // a released line goes to the pull-up level, never the last driven one
    assign line_o = irq_n_oe_o ? irq_n_o : 1'b1;
endmodule

// [sim/rtc_irq_props.sv]
`timescale 1ns/1ps
// ****
// port checks
// ****
module rtc_irq_props (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic low_volt1_status_i,
    input wire logic low_volt2_status_i,
    input wire logic recovery_status_i,
    input wire logic irq_n_o,
    input wire logic irq_n_oe_o
);
    wire logic hit = reg_addr_i == 8'h01 || reg_addr_i == 8'h02;
    wire logic en_wr = reg_wr_i && reg_addr_i == 8'h01;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    unmapped_read_a: assert property (reg_rd_i && !hit |=> reg_rdata_o == 8'h00) else $error("unmapped read");
    high_bits_a: assert property (reg_rd_i |=> reg_rdata_o[7:5] == 3'h0) else $error("bits 7:5 set");
    pin_low_a: assert property (irq_n_oe_o |-> irq_n_o == 1'b0) else $error("pin driven high");
    // a falling status bit may release the request without any write
    request_hold_a: assert property (irq_n_oe_o && !(reg_wr_i && hit) && !$fell(low_volt1_status_i) && !$fell(low_volt2_status_i) && !$fell(recovery_status_i) |=> irq_n_oe_o) else $error("request lost");
    enables_off_a: assert property (en_wr && reg_wdata_i[4:0] == 5'h00 |=> !irq_n_oe_o) else $error("stuck request");
    status_hold_a: assert property (en_wr && reg_wdata_i[2] && low_volt1_status_i |=> irq_n_oe_o) else $error("status");
    rdata_stand_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
    reset_state_a: assert property ($rose(resetn_i) |-> !irq_n_oe_o && reg_rdata_o == 8'h00) else $error("reset state");
endmodule
bind rtc_irq_and_alarm_match rtc_irq_props props_i (.*);

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [4:1] ev = 4'h0;
    logic [4:2] st = 3'h0;
    logic [15:0] alarm = 16'h7F85;
    logic [15:0] watch = 16'h0004;
    logic [7:0] rdata;
    logic irq_n, irq_oe, line;
    int n_errors = 0;
    int total_checks = 0;
    always #25 clk_i = ~clk_i;
    rtc_irq_and_alarm_match #(.FIELDS(2)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .alarm_fields_i(alarm),
        .watch_values_i(watch), .timer_zero_i(ev[1]), .low_volt1_event_i(ev[2]), .low_volt2_event_i(ev[3]),
        .recovery_event_i(ev[4]), .low_volt1_status_i(st[2]), .low_volt2_status_i(st[3]),
        .recovery_status_i(st[4]), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe));
    irq_host_model host (.irq_n_o(irq_n), .irq_n_oe_o(irq_oe), .line_o(line));
    // ****
    // access tasks
    // ****
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t read %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic exp);
        total_checks++;
        if (line !== exp) begin
            n_errors++;
            $display("[FAIL] %0t line %b want %b", $time, line, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_i);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        addr = a;
        rd = 1'b1;
        @(negedge clk_i);
        rd = 1'b0;
        cmp8(rdata, exp);
    endtask
    task automatic pulse(input int b);
        @(negedge clk_i);
        ev[b] = 1'b1;
        @(negedge clk_i);
        ev[b] = 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ****
    // tests
    // ****
    initial begin
        #(2000 * 50);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        rd_reg(8'h05, 8'h00);
        wr_reg(8'h01, 8'hFF);
        rd_reg(8'h01, 8'h1F);
        wr_reg(8'h01, 8'h00);
        pulse(1);
        rd_reg(8'h02, 8'h00);
        wr_reg(8'h01, 8'h02);
        pulse(1);
        cmp1(1'b0);
        wr_reg(8'h02, 8'hFF);
        rd_reg(8'h02, 8'h02);
        wr_reg(8'h02, 8'hFD);
        cmp1(1'b1);
        for (int b = 2; b < 5; b++) begin
            st[b] = 1'b1;
            wr_reg(8'h01, 8'(1 << b));
            pulse(b);
            rd_reg(8'h02, 8'(1 << b));
            wr_reg(8'h02, 8'h00);
            cmp1(1'b0);
            st[b] = 1'b0;
            @(negedge clk_i);
            cmp1(1'b1);
        end
        wr_reg(8'h01, 8'h01);
        // field 1 is disabled and would never match
        watch[6:0] = 7'h05;
        repeat (2) @(negedge clk_i);
        rd_reg(8'h02, 8'h01);
        wr_reg(8'h02, 8'h00);
        cmp1(1'b1);
        repeat (3) @(negedge clk_i);
        rd_reg(8'h02, 8'h00);
        watch[6:0] = 7'h06;
        @(negedge clk_i);
        watch[6:0] = 7'h05;
        repeat (2) @(negedge clk_i);
        rd_reg(8'h02, 8'h01);
        wr_reg(8'h01, 8'h03);
        pulse(1);
        wr_reg(8'h02, 8'hFE);
        cmp1(1'b0);
        rd_reg(8'h02, 8'h02);
        wr_reg(8'h02, 8'h00);
        cmp1(1'b1);
        end_of_test();
    end
endmodule
